// ==== rtl/wdt_pkg.sv ====
package wdt_pkg;
  localparam logic [11:0] WDT_CTRL_OFF   = 12'h000; // clock_ctrl_reg
  localparam logic [11:0] WDT_PERIOD_OFF = 12'h004; // wdt_period_reg
  localparam logic [11:0] WDT_COUNT_OFF  = 12'h008; // counters, read only
  localparam logic [11:0] WDT_IRQ_OFF    = 12'h00C; // irq_flag_reg, w1c
  localparam logic [11:0] WDT_MASK_OFF   = 12'h010; // irq mask
  localparam int CTRL_SRC_LSB   = 0;
  localparam int CTRL_BTCLR_BIT = 3;
  localparam int CTRL_RSEL_BIT  = 4;
  localparam int CTRL_RCSEL_BIT = 5;
  localparam int PER_CLR_BIT    = 7;
  localparam int IRQ_WDT_BIT    = 0;
  localparam int IRQ_BIT_BIT    = 1;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [6:0] PERIOD_RST = 7'h7F;
  localparam int RC_STEP_LOG2 = 8;
  localparam int DIV_MIN_LOG2 = 3;
  localparam int RST_PULSE_NS = 100;
  localparam int CLK_NS       = 20;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  typedef struct packed {
    logic [2:0] src;
    logic       rsel;
    logic       rcsel;
    logic [6:0] period;
    logic       bt_run;
    logic [9:0] pre;
    logic [7:0] interval_timer_count;
    logic [6:0] wcnt;
    logic [7:0] rcdiv;
    logic       in_stop;
    logic       rc_mode;
    logic [1:0] irq;
    logic [1:0] mask;
    logic [2:0] rstcnt;
    logic       rst_out;
    logic       main_on;
    logic       irq_out;
    logic       pready;
    logic [31:0] prdata;
    logic [2:0] stop_s;
    logic [2:0] rc_s;
  } wdt_state_t;
endpackage

// ==== rtl/wdt_top.sv ====
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module wdt_top
  import wdt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        stop_mode,
  input  wire logic        sub_clk_mode,
  input  wire logic        rc_osc_clk,
  output logic             wdt_reset_n,
  output logic             main_osc_on,
  output logic             irq
);
  wdt_state_t st_r;
  wdt_state_t st_nxt;

  // decode one register offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  logic        wr;
  logic        rd;
  logic        bt_tick;
  logic        rc_tick;
  logic        step;
  logic        match;
  logic [10:0] div_mask;

  always_comb begin
    st_nxt   = st_r;
    wr       = psel && penable && pwrite && st_r.pready;
    rd       = psel && !penable && !pwrite;
    // pin synchronisers for stop level and rc oscillator
    st_nxt.stop_s = {st_r.stop_s[1:0], stop_mode};
    st_nxt.rc_s   = {st_r.rc_s[1:0], rc_osc_clk};
    st_nxt.pready = psel && !penable;
    st_nxt.in_stop = st_r.stop_s[1];
    // rc source takes over at stop entry only
    if (st_r.stop_s[1] && !st_r.in_stop) begin
      st_nxt.rc_mode = st_r.rcsel;
    end else if (!st_r.stop_s[1]) begin
      st_nxt.rc_mode = 1'b0;
    end
    // prescaler divide 8..1024, frozen in stop unless rc_mode
    div_mask = 11'((11'h001 << (DIV_MIN_LOG2 + st_r.src)) - 11'h001);
    bt_tick  = 1'b0;
    if (!st_r.in_stop || st_r.rc_mode) begin
      st_nxt.pre = st_r.pre + 10'h001;
      if ((11'({1'b0, st_r.pre}) & div_mask) == div_mask) begin
        st_nxt.interval_timer_count = st_r.interval_timer_count + 8'h01;
        bt_tick     = (st_r.interval_timer_count == 8'hFF);
      end
    end
    // rc step every 256 rising rc edges
    rc_tick = 1'b0;
    if (st_r.rc_s[1] && !st_r.rc_s[2]) begin
      st_nxt.rcdiv = st_r.rcdiv + 8'h01;
      rc_tick      = (st_r.rcdiv == 8'hFF);
    end
    step  = st_r.bt_run && (st_r.rc_mode ? rc_tick : (bt_tick && !st_r.in_stop));
    match = (st_r.wcnt == st_r.period);
    if (step) begin
      st_nxt.wcnt = match ? 7'h00 : st_r.wcnt + 7'h01;
    end
    if (bt_tick) begin
      st_nxt.irq[IRQ_BIT_BIT] = 1'b1;
    end
    if (step && match) begin
      if (st_r.rsel) begin
        st_nxt.rstcnt  = 3'(RST_PULSE_CYC);
        st_nxt.main_on = 1'b1;
      end else begin
        st_nxt.irq[IRQ_WDT_BIT] = 1'b1;
      end
    end
    if (st_r.rstcnt != 3'h0) begin
      st_nxt.rstcnt = st_r.rstcnt - 3'h1;
    end
    st_nxt.rst_out = (st_nxt.rstcnt == 3'h0);
    if (!sub_clk_mode) begin
      st_nxt.main_on = 1'b1;
    end
    // register writes, clear bits act once
    if (wr) begin
      if (hit(paddr, WDT_CTRL_OFF)) begin
        st_nxt.src   = pwdata[CTRL_SRC_LSB +: 3];
        st_nxt.rsel  = pwdata[CTRL_RSEL_BIT];
        st_nxt.rcsel = pwdata[CTRL_RCSEL_BIT];
        if (pwdata[CTRL_BTCLR_BIT]) begin
          st_nxt.interval_timer_count   = 8'h00;
          st_nxt.pre    = 10'h000;
          st_nxt.bt_run = 1'b1;
        end
      end
      if (hit(paddr, WDT_PERIOD_OFF)) begin
        st_nxt.period = pwdata[6:0];
        if (pwdata[PER_CLR_BIT]) begin
          st_nxt.wcnt = 7'h00;
        end
      end
      if (hit(paddr, WDT_IRQ_OFF)) begin
        st_nxt.irq = st_r.irq & ~pwdata[1:0]; // write one to clear
        if (step && match && !st_r.rsel) begin
          st_nxt.irq[IRQ_WDT_BIT] = 1'b1;
        end
        if (bt_tick) begin
          st_nxt.irq[IRQ_BIT_BIT] = 1'b1;
        end
      end
      if (hit(paddr, WDT_MASK_OFF)) begin
        st_nxt.mask = pwdata[1:0];
      end
    end
    st_nxt.irq_out = |(st_nxt.irq & st_nxt.mask);
    // read data captured in setup phase
    st_nxt.prdata = 32'h0000_0000;
    if (rd) begin
      case (paddr)
        WDT_CTRL_OFF:   st_nxt.prdata = {26'h0, st_r.rcsel, st_r.rsel, 1'b0, st_r.src};
        WDT_PERIOD_OFF: st_nxt.prdata = {25'h0, st_r.period};
        WDT_COUNT_OFF:  st_nxt.prdata = {17'h0, st_r.wcnt, st_r.interval_timer_count};
        WDT_IRQ_OFF:    st_nxt.prdata = {30'h0, st_r.irq};
        WDT_MASK_OFF:   st_nxt.prdata = {30'h0, st_r.mask};
        default:        st_nxt.prdata = 32'h0000_0000;
      endcase
    end else if (!psel) begin
      st_nxt.prdata = 32'h0000_0000;
    end else begin
      st_nxt.prdata = st_r.prdata;
    end
  end

  // single state register; reset disables watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r         <= '0;
      st_r.src     <= CTRL_RST[2:0];
      st_r.period  <= PERIOD_RST;
      st_r.rst_out <= 1'b1;
      st_r.main_on <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready      = st_r.pready;
  assign prdata      = st_r.prdata;
  assign pslverr     = 1'b0;
  assign wdt_reset_n = st_r.rst_out;
  assign main_osc_on = st_r.main_on;
  assign irq         = st_r.irq_out;
endmodule

// ==== tb/wdt_chk.sv ====
`timescale 1ns/1ps
module wdt_chk
  import wdt_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        sub_clk_mode,
  input wire logic        wdt_reset_n,
  input wire logic        main_osc_on,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // chip reset pulse: five low cycles then high
  sequence s_pulse;
    !wdt_reset_n [*5] ##1 wdt_reset_n;
  endsequence
  // bus answer timing
  a_ready_access: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held");
  a_no_slverr: assert property (!pslverr) else $error("slverr set");
  a_unmapped_zero: assert property (psel && penable && pready && !pwrite && paddr > 12'h013
    |-> prdata == 32'h0) else $error("unmapped read");
  // interrupt, reset and oscillator outputs
  a_mask_off: assert property (psel && penable && pready && pwrite
    && paddr == WDT_MASK_OFF && pwdata[1:0] == 2'h0 |-> ##2 !irq) else $error("masked irq");
  a_rst_pulse: assert property ($fell(wdt_reset_n) |-> s_pulse) else $error("bad pulse");
  a_osc_back_on: assert property (!wdt_reset_n |-> ##[0:2] main_osc_on) else $error("osc");
  a_osc_main: assert property (!sub_clk_mode |=> main_osc_on) else $error("osc main");
endmodule
bind wdt_top wdt_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .prdata, .pslverr, .sub_clk_mode, .wdt_reset_n, .main_osc_on, .irq);

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb import wdt_pkg::*;;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sub_clk_mode = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, prdata, save;
  logic        stop_mode = 0, rc_osc_clk = 0;
  logic        pready, pslverr, wdt_reset_n, main_osc_on, irq;
  logic [75:0] rows [4];
  int          mismatches = 0, comparisons = 0, cyc = 0, n;
  wdt_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .stop_mode, .sub_clk_mode, .rc_osc_clk, .wdt_reset_n, .main_osc_on,
    .irq);
  // clock and hang guard
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches = mismatches + 1;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one bus transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    rows = '{{WDT_CTRL_OFF, 32'h2F, 32'h27}, {WDT_PERIOD_OFF, 32'h85, 32'h05},
             {WDT_MASK_OFF, 32'h3, 32'h3}, {12'h020, 32'hFFFFFFFF, 32'h0}};
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, WDT_CTRL_OFF, 0);
    chk(rd, 0);
    apb(0, WDT_PERIOD_OFF, 0);
    chk(rd, 32'h7F);
    // write then read back each row
    foreach (rows[i]) begin
      apb(1, rows[i][75:64], rows[i][63:32]);
      apb(0, rows[i][75:64], 0);
      chk(rd, rows[i][31:0]);
    end
    // watchdog interrupt, masking and clearing
    apb(1, WDT_MASK_OFF, 1);
    apb(1, WDT_CTRL_OFF, 32'h08);
    apb(1, WDT_PERIOD_OFF, 32'h81);
    n = 0;
    while (irq !== 1'h1) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n >= 1900 && n <= 4400), 1);
    apb(0, WDT_IRQ_OFF, 0);
    chk(rd[0], 1);
    apb(1, WDT_MASK_OFF, 0);
    repeat (3) @(posedge pclk);
    chk(irq, 0);
    apb(1, WDT_MASK_OFF, 1);
    apb(1, WDT_IRQ_OFF, 1);
    repeat (3) @(posedge pclk);
    chk(irq, 0);
    // periodic clearing keeps the watchdog quiet
    apb(1, WDT_PERIOD_OFF, 32'h81);
    apb(1, WDT_IRQ_OFF, 1);
    repeat (6) begin
      repeat (900) @(posedge pclk);
      apb(1, WDT_PERIOD_OFF, 32'h81);
    end
    chk(irq, 0);
    // stop mode on system clock freezes the counters
    stop_mode <= 1;
    repeat (4) @(posedge pclk);
    apb(0, WDT_COUNT_OFF, 0);
    save = rd;
    repeat (2500) @(posedge pclk);
    apb(0, WDT_COUNT_OFF, 0);
    chk(rd, save);
    stop_mode <= 0;
    repeat (2100) @(posedge pclk);
    apb(0, WDT_COUNT_OFF, 0);
    chk(32'(rd[14:0] != save[14:0]), 1);
    // rc source chosen at stop entry, one step per 256 rising rc edges
    apb(1, WDT_CTRL_OFF, 32'h20);
    apb(1, WDT_PERIOD_OFF, 32'h85);
    stop_mode <= 1;
    repeat (4) @(posedge pclk);
    apb(0, WDT_COUNT_OFF, 0);
    save = rd;
    repeat (256) begin
      rc_osc_clk <= 1;
      repeat (4) @(posedge pclk);
      rc_osc_clk <= 0;
      repeat (4) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
    apb(0, WDT_COUNT_OFF, 0);
    chk(32'(rd[14:8]), 32'(save[14:8] + 7'h01));
    stop_mode <= 0;
    repeat (4) @(posedge pclk);
    // watchdog reset while on sub clock
    sub_clk_mode <= 1;
    apb(1, WDT_CTRL_OFF, 32'h18);
    apb(1, WDT_PERIOD_OFF, 32'h81);
    while (wdt_reset_n !== 1'h0) @(posedge pclk);
    repeat (2) @(posedge pclk);
    chk(main_osc_on, 1);
    chk(wdt_reset_n, 0);
    final_report();
  end
endmodule
